/* File: logic/emss_sequencer.v */
`timescale 1ns/1ps
`include "emss_regs.vh"

module emss_sequencer
(
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire [2:0] cfg_exp_count_i,
  input wire cfg_diff_i,
  input wire [1:0] cfg_mode_i,
  input wire [4:0] cfg_list_len_i,
  input wire [4:0] cfg_range_first_i,
  input wire [4:0] cfg_range_last_i,
  input wire [2:0] cfg_single_unit_i,
  input wire [5:0] cfg_single_chan_i,
  input wire list_wr_i,
  input wire [3:0] list_wr_addr_i,
  input wire [4:0] list_wr_data_i,
  input wire start_i,
  input wire sample_done_i,
  output reg [3:0] board_chan_o,
  output reg [1:0] exp_unit_o,
  output reg [5:0] exp_chan_o,
  output reg exp_sel_valid_o,
  output reg sample_req_o,
  output reg busy_o,
  output reg scan_done_o,
  output reg scan_err_o
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_LOAD = 5'h02;
  localparam [4:0] ST_SET = 5'h04;
  localparam [4:0] ST_WAIT = 5'h08;
  localparam [4:0] ST_END = 5'h10;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Three units is not a legal wiring, so it fails the start like any other bad count
  function count_ok;
    input [2:0] count;
    begin
      case (count)
        3'h0, 3'h1, 3'h2, 3'h4: count_ok = 1'b1;
        default: count_ok = 1'b0;
      endcase
    end
  endfunction

  function [1:0] last_unit;
    input [2:0] count;
    begin
      case (count)
        3'h2: last_unit = 2'h1;
        3'h4: last_unit = 2'h3;
        default: last_unit = 2'h0;
      endcase
    end
  endfunction

  // Expander channel ranges map back to the same board range, so one check serves both
  function board_ok;
    input [4:0] chan;
    input diff;
    begin
      board_ok = diff ? (chan <= `EMSS_DIFF_BOARD_LAST) : (chan <= `EMSS_SE_BOARD_LAST);
    end
  endfunction

  // Differential wiring pairs the unit inputs, halving the usable channels
  function exp_ok;
    input [5:0] chan;
    input diff;
    begin
      exp_ok = diff ? (chan <= `EMSS_DIFF_EXP_LAST) : (chan <= `EMSS_SE_EXP_LAST);
    end
  endfunction

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  reg [4:0] list_mem [0:15];
  reg [4:0] state_reg;
  reg [1:0] mode_reg;
  reg [2:0] count_reg;
  reg diff_reg;
  reg [4:0] last_pos_reg;
  reg [4:0] pos_reg;
  reg [3:0] board_reg;
  reg [1:0] single_unit_reg;
  reg [5:0] single_chan_reg;
  reg clear_reg;

  wire [1:0] sub_w;
  wire [1:0] unit_w;
  wire last_step_w;
  wire [4:0] entry_w;
  wire entry_last_w;
  wire cfg_ok_w;
  wire single_ok_w;
  wire range_ok_w;
  wire list_ok_w;
  wire [1:0] last_unit_w;
  wire single_w;
  wire step_w;

  // ----------------------------------------------------------------
  // Start-time checks
  // ----------------------------------------------------------------
  assign single_ok_w = (cfg_exp_count_i != 3'h0) && (cfg_single_unit_i != 3'h0) &&
                       (cfg_single_unit_i <= cfg_exp_count_i) &&
                       exp_ok(cfg_single_chan_i, cfg_diff_i);
  assign range_ok_w = (cfg_range_first_i <= cfg_range_last_i) &&
                      board_ok(cfg_range_last_i, cfg_diff_i);
  assign list_ok_w = (cfg_list_len_i != 5'h00) && (cfg_list_len_i <= `EMSS_LIST_DEPTH);
  // Mode 3 is not a scan mode and fails the start
  assign cfg_ok_w = count_ok(cfg_exp_count_i) &&
                    ((cfg_mode_i == `EMSS_MODE_LIST) ? list_ok_w :
                     (cfg_mode_i == `EMSS_MODE_SINGLE) ? single_ok_w :
                     (cfg_mode_i == `EMSS_MODE_RANGE) ? range_ok_w : 1'b0);

  // List mode reads the stored entry, range mode walks board numbers directly
  assign entry_w = (mode_reg == `EMSS_MODE_LIST) ? list_mem[pos_reg[3:0]] : pos_reg;
  assign entry_last_w = (pos_reg == last_pos_reg);

  // ----------------------------------------------------------------
  // Expander sub-step and unit counters
  // ----------------------------------------------------------------
  // The counters step on the very edge that leaves WAIT, so SET already sees
  // the next sub-step; a step one cycle later would repeat the first channel
  assign single_w = (mode_reg == `EMSS_MODE_SINGLE);
  assign last_unit_w = last_unit(count_reg);
  assign step_w = (state_reg == ST_WAIT) && sample_done_i && !single_w &&
                  (count_reg != 3'h0) && !last_step_w;

  emss_step_ctr u_step_ctr
  (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(clear_reg),
    .step_i(step_w),
    .last_unit_i(last_unit_w),
    .sub_o(sub_w),
    .unit_o(unit_w),
    .last_o(last_step_w)
  );

  // ----------------------------------------------------------------
  // Scan list writes
  // ----------------------------------------------------------------
  // Writes during a scan are dropped so the running order cannot change under it
  always @(posedge ref_clk_i)
  begin
    if (list_wr_i && (state_reg == ST_IDLE))
    begin
      list_mem[list_wr_addr_i] <= list_wr_data_i;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= ST_IDLE;
      mode_reg <= `EMSS_MODE_LIST;
      count_reg <= 3'h0;
      diff_reg <= 1'b0;
      last_pos_reg <= 5'h00;
      pos_reg <= 5'h00;
      board_reg <= 4'h0;
      single_unit_reg <= 2'h0;
      single_chan_reg <= 6'h00;
      clear_reg <= 1'b0;
      board_chan_o <= 4'h0;
      exp_unit_o <= 2'h0;
      exp_chan_o <= 6'h00;
      exp_sel_valid_o <= 1'b0;
      sample_req_o <= 1'b0;
      busy_o <= 1'b0;
      scan_done_o <= 1'b0;
      scan_err_o <= 1'b0;
    end
    else
    begin
      clear_reg <= 1'b0;
      sample_req_o <= 1'b0;
      scan_done_o <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (start_i)
          begin
            // Configuration is frozen here for the whole scan
            mode_reg <= cfg_mode_i;
            count_reg <= cfg_exp_count_i;
            diff_reg <= cfg_diff_i;
            single_unit_reg <= cfg_single_unit_i[1:0] - 2'h1;
            single_chan_reg <= cfg_single_chan_i;
            pos_reg <= (cfg_mode_i == `EMSS_MODE_RANGE) ? cfg_range_first_i : 5'h00;
            last_pos_reg <= (cfg_mode_i == `EMSS_MODE_RANGE) ? cfg_range_last_i :
                            cfg_list_len_i - 5'h01;
            clear_reg <= 1'b1;
            scan_err_o <= 1'b0;
            busy_o <= 1'b1;
            if (cfg_ok_w)
            begin
              state_reg <= (cfg_mode_i == `EMSS_MODE_SINGLE) ? ST_SET : ST_LOAD;
            end
            else
            begin
              scan_err_o <= 1'b1;
              state_reg <= ST_END;
            end
          end
        end
        ST_LOAD:
        begin
          // A bad entry stops the scan; samples already taken stand
          if (board_ok(entry_w, diff_reg))
          begin
            board_reg <= entry_w[3:0];
            state_reg <= ST_SET;
          end
          else
          begin
            scan_err_o <= 1'b1;
            state_reg <= ST_END;
          end
        end
        ST_SET:
        begin
          exp_sel_valid_o <= (count_reg != 3'h0);
          sample_req_o <= 1'b1;
          state_reg <= ST_WAIT;
          if (single_w)
          begin
            // Only the named channel of the named unit is sampled
            board_chan_o <= single_chan_reg[5:2];
            exp_unit_o <= single_unit_reg;
            exp_chan_o <= single_chan_reg;
          end
          else if (count_reg == 3'h0)
          begin
            board_chan_o <= board_reg;
            exp_unit_o <= 2'h0;
            exp_chan_o <= 6'h00;
          end
          else
          begin
            board_chan_o <= board_reg;
            exp_unit_o <= unit_w;
            exp_chan_o <= {board_reg, sub_w};
          end
        end
        ST_WAIT:
        begin
          if (sample_done_i)
          begin
            if (single_w || (count_reg == 3'h0) || last_step_w)
            begin
              clear_reg <= 1'b1;
              if (single_w || entry_last_w)
              begin
                state_reg <= ST_END;
              end
              else
              begin
                pos_reg <= pos_reg + 5'h01;
                state_reg <= ST_LOAD;
              end
            end
            else
            begin
              // The counters advance on this same edge through step_w
              state_reg <= ST_SET;
            end
          end
        end
        ST_END:
        begin
          // One cycle to close the scan; the error level stays until the next start
          busy_o <= 1'b0;
          exp_sel_valid_o <= 1'b0;
          scan_done_o <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default:
        begin
          state_reg <= ST_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

endmodule // emss_sequencer

/* File: logic/emss_regs.vh */
`ifndef EMSS_REGS_VH
`define EMSS_REGS_VH

// ----------------------------------------------------------------
// Scan modes
// ----------------------------------------------------------------
`define EMSS_MODE_LIST 2'h0
`define EMSS_MODE_SINGLE 2'h1
`define EMSS_MODE_RANGE 2'h2

// ----------------------------------------------------------------
// Sizes and limits
// ----------------------------------------------------------------
`define EMSS_LIST_DEPTH 5'h10
`define EMSS_SE_BOARD_LAST 5'h0F
`define EMSS_DIFF_BOARD_LAST 5'h07
`define EMSS_SE_EXP_LAST 6'h3F
`define EMSS_DIFF_EXP_LAST 6'h1F
`define EMSS_SUB_LAST 2'h3

`endif

/* File: logic/emss_step_ctr.v */
`timescale 1ns/1ps
`include "emss_regs.vh"

module emss_step_ctr
(
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire clear_i,
  input wire step_i,
  input wire [1:0] last_unit_i,
  output reg [1:0] sub_o,
  output reg [1:0] unit_o,
  output wire last_o
);

  // Sub-step runs innermost so one unit's four channels finish before the next unit
  assign last_o = (sub_o == `EMSS_SUB_LAST) && (unit_o == last_unit_i);

  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i || clear_i)
    begin
      sub_o <= 2'h0;
      unit_o <= 2'h0;
    end
    else if (step_i)
    begin
      if (sub_o == `EMSS_SUB_LAST)
      begin
        sub_o <= 2'h0;
        unit_o <= (unit_o == last_unit_i) ? 2'h0 : unit_o + 2'h1;
      end
      else
      begin
        sub_o <= sub_o + 2'h1;
      end
    end
  end

endmodule // emss_step_ctr

/* File: bench/emss_chk.sv */
`timescale 1ns/1ps
module emss_chk (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire [2:0] cfg_exp_count_i,
  input wire [1:0] cfg_mode_i,
  input wire start_i,
  input wire [3:0] board_chan_o,
  input wire [1:0] exp_unit_o,
  input wire [5:0] exp_chan_o,
  input wire exp_sel_valid_o,
  input wire sample_req_o,
  input wire busy_o,
  input wire scan_done_o,
  input wire scan_err_o
);
  // ----
  // Step tracking
  // ----
  // Compares request to request, so the check holds for any partner latency
  reg [5:0] last_chan_reg;
  reg [1:0] last_unit_reg;
  reg have_reg;
  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i || scan_done_o)
      have_reg <= 1'b0;
    else if (sample_req_o)
      have_reg <= exp_sel_valid_o;
    if (sample_req_o)
    begin
      last_chan_reg <= exp_chan_o;
      last_unit_reg <= exp_unit_o;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_req_pulse: assert property (sample_req_o |=> !sample_req_o)
    else $error("long request");
  a_addr_map: assert property (
    sample_req_o && exp_sel_valid_o |-> exp_chan_o[5:2] == board_chan_o)
    else $error("bad channel map");
  a_unit_range: assert property (
    sample_req_o && exp_sel_valid_o |-> {1'b0, exp_unit_o} < cfg_exp_count_i)
    else $error("unit out of range");
  a_no_exp: assert property (
    sample_req_o && cfg_exp_count_i == 3'h0 |-> !exp_sel_valid_o)
    else $error("expander used");
  a_sub_step: assert property (
    sample_req_o && have_reg && last_chan_reg[1:0] != 2'h3
    |-> exp_chan_o == last_chan_reg + 6'h01 && exp_unit_o == last_unit_reg)
    else $error("bad sub step");
  a_unit_step: assert property (
    sample_req_o && have_reg && last_chan_reg[1:0] == 2'h3
    && {1'b0, last_unit_reg} + 3'h1 < cfg_exp_count_i
    |-> exp_unit_o == last_unit_reg + 2'h1 && exp_chan_o == last_chan_reg - 6'h03)
    else $error("bad unit step");
  a_start_ans: assert property (
    start_i && !busy_o && !scan_done_o && cfg_mode_i != 2'h1
    |-> ##[3:4] (sample_req_o || scan_err_o))
    else $error("no first request");
  a_err_end: assert property ($rose(scan_err_o) |=> scan_done_o && !busy_o)
    else $error("error not ended");
  c_unit_four: cover property (sample_req_o && exp_unit_o == 2'h3);
  c_err_done: cover property (scan_err_o && scan_done_o);
  c_direct: cover property (sample_req_o && !exp_sel_valid_o);
endmodule // emss_chk

/* File: bench/emss_exp_model.sv */
`timescale 1ns/1ps
module emss_exp_model (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire req_i,
  input wire [3:0] board_i,
  input wire [1:0] unit_i,
  input wire [5:0] chan_i,
  input wire valid_i,
  input wire [3:0] lat_i,
  output reg done_o
);
  // ----
  // Expander answer
  // ----
  // Unit logs as 0 when no expander is addressed, since it is then meaningless
  reg [12:0] log [$];
  reg [4:0] wait_reg;
  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      wait_reg <= 5'h00;
      done_o <= 1'b0;
    end
    else if (req_i)
    begin
      log.push_back({valid_i, valid_i ? unit_i : 2'h0, chan_i, board_i});
      wait_reg <= {1'b0, lat_i} + 5'h01;
      done_o <= (lat_i == 4'h0);
    end
    else
    begin
      wait_reg <= (wait_reg == 5'h00) ? 5'h00 : wait_reg - 5'h01;
      done_o <= (wait_reg == 5'h02);
    end
  end
endmodule // emss_exp_model

/* File: bench/tb_emss_sequencer.sv */
`timescale 1ns/1ps
module tb_emss_sequencer;
  reg ref_clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg [2:0] cfg_exp_count_i = 3'h0;
  reg cfg_diff_i = 1'b0;
  reg [1:0] cfg_mode_i = 2'h0;
  reg [4:0] cfg_list_len_i = 5'h03;
  reg [4:0] cfg_range_first_i = 5'h0E;
  reg [4:0] cfg_range_last_i = 5'h0F;
  reg [2:0] cfg_single_unit_i = 3'h4;
  reg [5:0] cfg_single_chan_i = 6'h08;
  reg list_wr_i = 1'b0;
  reg [3:0] list_wr_addr_i = 4'h0;
  reg [4:0] list_wr_data_i = 5'h00;
  reg start_i = 1'b0;
  reg [3:0] lat = 4'h0;
  wire sample_done_i;
  wire [3:0] board_chan_o;
  wire [1:0] exp_unit_o;
  wire [5:0] exp_chan_o;
  wire exp_sel_valid_o, sample_req_o, busy_o, scan_done_o, scan_err_o;
  integer errors = 0;
  integer checked = 0;
  reg [12:0] exq [$];
  emss_sequencer i_emss_sequencer (.ref_clk_i, .sys_rst_i, .cfg_exp_count_i, .cfg_diff_i,
    .cfg_mode_i, .cfg_list_len_i, .cfg_range_first_i, .cfg_range_last_i, .cfg_single_unit_i,
    .cfg_single_chan_i, .list_wr_i, .list_wr_addr_i, .list_wr_data_i, .start_i,
    .sample_done_i, .board_chan_o, .exp_unit_o, .exp_chan_o, .exp_sel_valid_o,
    .sample_req_o, .busy_o, .scan_done_o, .scan_err_o);
  emss_exp_model i_emss_exp_model (.ref_clk_i, .sys_rst_i, .req_i(sample_req_o),
    .board_i(board_chan_o), .unit_i(exp_unit_o), .chan_i(exp_chan_o),
    .valid_i(exp_sel_valid_o), .lat_i(lat), .done_o(sample_done_i));
  // ----
  // Tasks
  // ----
  task chk(input string nm, input [12:0] seen, input [12:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("mismatch %0s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task add(input [3:0] e);
    integer u, s;
  begin
    if (cfg_exp_count_i == 3'h0)
      exq.push_back({9'h000, e});
    for (u = 0; u < cfg_exp_count_i; u = u + 1)
      for (s = 0; s < 4; s = s + 1)
        exq.push_back({1'b1, u[1:0], e, s[1:0], e});
  end
  endtask
  task wr(input [3:0] a, input [4:0] d);
  begin
    @(posedge ref_clk_i);
    #1 list_wr_i = 1'b1;
    list_wr_addr_i = a;
    list_wr_data_i = d;
    @(posedge ref_clk_i);
    #1 list_wr_i = 1'b0;
  end
  endtask
  task run(input e);
    integer k;
  begin
    i_emss_exp_model.log.delete();
    @(posedge ref_clk_i);
    #1 start_i = 1'b1;
    @(posedge ref_clk_i);
    #1 start_i = 1'b0;
    k = 0;
    while (scan_done_o !== 1'b1 && k < 3000)
    begin
      @(posedge ref_clk_i);
      #1 k = k + 1;
    end
    chk("scan end", k < 3000, 1'b1);
    chk("error flag", scan_err_o, e);
    chk("sample count", i_emss_exp_model.log.size(), exq.size());
    foreach (exq[j])
      chk("sample", i_emss_exp_model.log[j], exq[j]);
    exq.delete();
  end
  endtask
  task t_list;
    integer n;
  begin
    wr(4'h0, 5'h02);
    wr(4'h1, 5'h0F);
    wr(4'h2, 5'h00);
    for (n = 0; n < 4; n = n + 1)
    begin
      cfg_exp_count_i = (n == 3) ? 3'h4 : n[2:0];
      lat = n[3:0];
      add(4'h2);
      add(4'hF);
      add(4'h0);
      run(1'b0);
    end
    $display("list test done");
  end
  endtask
  task t_range;
  begin
    cfg_mode_i = 2'h2;
    add(4'hE);
    add(4'hF);
    run(1'b0);
    $display("range test done");
  end
  endtask
  task t_single;
  begin
    cfg_mode_i = 2'h1;
    exq.push_back({1'b1, 2'h3, 6'h08, 4'h2});
    run(1'b0);
    $display("single test done");
  end
  endtask
  task t_err;
  begin
    cfg_mode_i = 2'h0;
    cfg_diff_i = 1'b1;
    cfg_exp_count_i = 3'h1;
    cfg_list_len_i = 5'h02;
    wr(4'h0, 5'h03);
    wr(4'h1, 5'h09);
    add(4'h3);
    run(1'b1);
    cfg_exp_count_i = 3'h3;
    run(1'b1);
    cfg_exp_count_i = 3'h1;
    cfg_mode_i = 2'h3;
    run(1'b1);
    $display("error test done");
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  initial
  begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    repeat (4) @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b0;
    t_list;
    t_range;
    t_single;
    t_err;
    end_sim;
  end
  // Tests need under 1000 cycles; ten times that margin catches a hang
  initial
  begin
    #100000;
    errors = errors + 1;
    end_sim;
  end
endmodule // tb_emss_sequencer
bind emss_sequencer emss_chk i_emss_chk (.ref_clk_i, .sys_rst_i, .cfg_exp_count_i,
  .cfg_mode_i, .start_i, .board_chan_o, .exp_unit_o, .exp_chan_o, .exp_sel_valid_o,
  .sample_req_o, .busy_o, .scan_done_o, .scan_err_o);
